// ==== rtl/input_capture_control.sv ====
// One input capture channel: pin synchroniser, edge qualifier, capture buffer,
// event prescaler, control register, sticky interrupt status and mask.
// Assumes timer values arrive on CLK_SYS; the capture pin is asynchronous.
//
// Contract
// - Enable bit runs channel; clear resets and stops.
// - Stop-in-idle halts channel during Idle mode.
// - Mode 110 first capture on selected edge.
// - Wide select stores 32-bit timer value.
// - Source select picks timer in 16-bit capture.
// - Interrupt after one to four capture events.
// - Overflow flag reads one after overflow.
// - Buffer-not-empty flag shows unread captures.
`timescale 1ns/1ps

module input_capture_control #(
  parameter int DEPTH = 4
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire capture_pkg::bus_req_t BUS_REQ,
  output logic [capture_pkg::DATA_W-1:0] RDATA,
  input wire logic CAP_PIN,
  input wire logic [15:0] TMR_SECOND,
  input wire logic [15:0] TMR_THIRD,
  input wire logic IDLE_MODE,
  output logic IRQ
);
  import capture_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  ctrl_t ctrl_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_prev_q;
  logic [DATA_W-1:0] buf_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  logic ovf_q;
  logic [1:0] evt_cnt_q;
  logic [STAT_W-1:0] status_q;
  logic [STAT_W-1:0] status_d;
  logic [STAT_W-1:0] mask_q;
  logic [DATA_W-1:0] rdata_q;
  logic irq_q;
  edge_state_t state_q;

  logic active;
  logic rise;
  logic fall;
  logic edge_hit;
  logic capture;
  logic empty;
  logic full;
  logic push;
  logic pop;
  logic int_evt;
  logic wr_ctrl;
  logic rd_stat;
  logic [DATA_W-1:0] stamp;
  logic [DATA_W-1:0] rd_word;

  assign RDATA = rdata_q;
  assign IRQ = irq_q;

  // A stopped channel sees no edges, so no capture and no interrupt source.
  assign active = ctrl_q.on & ~(ctrl_q.stop_idle & IDLE_MODE);
  assign rise = pin_s2_q & ~pin_prev_q;
  assign fall = ~pin_s2_q & pin_prev_q;
  assign empty = (count_q == '0);
  assign full = (count_q == FULL_COUNT);
  assign capture = active & edge_hit;
  assign push = capture & ~full;
  assign pop = BUS_REQ.rd & (BUS_REQ.addr == OFF_BUF) & ~empty;
  assign int_evt = capture & (evt_cnt_q == ctrl_q.evt_div);
  assign wr_ctrl = BUS_REQ.wr & (BUS_REQ.addr == OFF_CTRL);
  assign rd_stat = BUS_REQ.rd & (BUS_REQ.addr == OFF_STAT);

  // The two timers pair into one 32-bit value, the third timer as upper half.
  always_comb
  begin
    if (ctrl_q.wide)
    begin
      stamp = {TMR_THIRD, TMR_SECOND};
    end
    else if (ctrl_q.tmr_sel)
    begin
      stamp = {16'h0000, TMR_SECOND};
    end
    else
    begin
      stamp = {16'h0000, TMR_THIRD};
    end
  end

  always_comb
  begin
    case (ctrl_q.mode)
      MODE_EVERY:
        edge_hit = rise | fall;
      MODE_FALL:
        edge_hit = fall;
      MODE_RISE:
        edge_hit = rise;
      MODE_FIRST:
      begin
        if (state_q == S_ARM)
        begin
          edge_hit = ctrl_q.first_edge ? rise : fall;
        end
        else
        begin
          edge_hit = rise | fall;
        end
      end
      default:
        edge_hit = 1'b0;
    endcase
  end

  // The first stage feeds only the second; edges are taken from the second.
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= CAP_PIN;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // Unused bits are simply not stored, so they read zero.
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl_q.on <= BUS_REQ.wdata[ON_BIT];
      ctrl_q.stop_idle <= BUS_REQ.wdata[IDLE_STOP_BIT];
      ctrl_q.first_edge <= BUS_REQ.wdata[FIRST_EDGE_BIT];
      ctrl_q.wide <= BUS_REQ.wdata[WIDE_BIT];
      ctrl_q.tmr_sel <= BUS_REQ.wdata[TMR_BIT];
      ctrl_q.evt_div <= BUS_REQ.wdata[EVT_LSB +: 2];
      ctrl_q.mode <= BUS_REQ.wdata[MODE_LSB +: 3];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q <= S_ARM;
    end
    else if (!ctrl_q.on || ctrl_q.mode != MODE_FIRST)
    begin
      state_q <= S_ARM;
    end
    else
    begin
      case (state_q)
        S_ARM:
        begin
          if (capture)
          begin
            state_q <= S_RUN;
          end
        end
        S_RUN:
          state_q <= S_RUN;
        default:
          state_q <= S_ARM;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_slot
      always_ff @(posedge CLK_SYS or negedge RSTN)
      begin
        if (!RSTN)
        begin
          buf_q[gi] <= '0;
        end
        else if (push && wr_ptr_q == PW'(gi))
        begin
          buf_q[gi] <= stamp;
        end
      end
    end
  endgenerate

  // Disabling the channel empties the buffer and forgets any overflow.
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ovf_q <= 1'b0;
    end
    else if (!ctrl_q.on)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ovf_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= (wr_ptr_q == LAST_SLOT) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= (rd_ptr_q == LAST_SLOT) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
      if (capture && full)
      begin
        ovf_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      evt_cnt_q <= '0;
    end
    else if (!ctrl_q.on)
    begin
      evt_cnt_q <= '0;
    end
    else if (capture)
    begin
      evt_cnt_q <= int_evt ? 2'h0 : evt_cnt_q + 1'b1;
    end
  end

  // A new event in the cycle of the clearing read still sets its bit.
  always_comb
  begin
    status_d = rd_stat ? '0 : status_q;
    status_d[ST_CAP] = status_d[ST_CAP] | int_evt;
    status_d[ST_OVF] = status_d[ST_OVF] | (capture & full);
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      status_q <= '0;
      mask_q <= '0;
    end
    else
    begin
      status_q <= status_d;
      if (BUS_REQ.wr && BUS_REQ.addr == OFF_MASK)
      begin
        mask_q <= BUS_REQ.wdata[STAT_W-1:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= ctrl_q.on & |(status_d & mask_q);
    end
  end

  always_comb
  begin
    rd_word = '0;
    case (BUS_REQ.addr)
      OFF_CTRL:
      begin
        rd_word[ON_BIT] = ctrl_q.on;
        rd_word[IDLE_STOP_BIT] = ctrl_q.stop_idle;
        rd_word[FIRST_EDGE_BIT] = ctrl_q.first_edge;
        rd_word[WIDE_BIT] = ctrl_q.wide;
        rd_word[TMR_BIT] = ctrl_q.tmr_sel;
        rd_word[EVT_LSB +: 2] = ctrl_q.evt_div;
        rd_word[OVF_BIT] = ovf_q;
        rd_word[BNE_BIT] = ~empty;
        rd_word[MODE_LSB +: 3] = ctrl_q.mode;
      end
      OFF_BUF:
        rd_word = empty ? '0 : buf_q[rd_ptr_q];
      OFF_STAT:
        rd_word[STAT_W-1:0] = status_q;
      OFF_MASK:
        rd_word[STAT_W-1:0] = mask_q;
      default:
        rd_word = '0;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= BUS_REQ.rd ? rd_word : '0;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  sequence s_arm_selected;
    state_q == S_ARM && ctrl_q.mode == MODE_FIRST && active && !full;
  endsequence

  sequence s_last_event;
    capture && evt_cnt_q == ctrl_q.evt_div;
  endsequence

  a_off_flush: assert property (!ctrl_q.on |=> count_q == '0 && !ovf_q && !IRQ)
    else $error("disabled channel kept buffer, overflow or interrupt");

  a_idle_halt: assert property (ctrl_q.stop_idle && IDLE_MODE |=> $stable(wr_ptr_q))
    else $error("capture taken while halted in idle");

  a_first_edge: assert property (s_arm_selected ##0 (ctrl_q.first_edge ? fall : rise)
    |=> $stable(wr_ptr_q) && state_q == S_ARM)
    else $error("first capture taken on the wrong edge");

  a_wide_value: assert property (push && ctrl_q.wide
    |=> buf_q[$past(wr_ptr_q)] == {$past(TMR_THIRD), $past(TMR_SECOND)})
    else $error("wide capture stored the wrong value");

  a_narrow_src: assert property (push && !ctrl_q.wide && !ctrl_q.tmr_sel
    |=> buf_q[$past(wr_ptr_q)] == {16'h0000, $past(TMR_THIRD)})
    else $error("narrow capture used the wrong timer");

  a_event_count: assert property (s_last_event |=> status_q[ST_CAP] && evt_cnt_q == 2'h0)
    else $error("interrupt event not raised after set capture count");

  a_ovf_read: assert property (BUS_REQ.rd && BUS_REQ.addr == OFF_CTRL
    |=> RDATA[OVF_BIT] == $past(ovf_q))
    else $error("overflow flag misreported");

  a_bne_read: assert property (BUS_REQ.rd && BUS_REQ.addr == OFF_CTRL
    |=> RDATA[BNE_BIT] == !$past(empty))
    else $error("buffer-not-empty flag misreported");

  a_full_drop: assert property (capture && full |=> $stable(wr_ptr_q) && ovf_q
    && status_q[ST_OVF])
    else $error("capture into full buffer not flagged");

  a_unused_zero: assert property (BUS_REQ.rd && BUS_REQ.addr == OFF_CTRL
    |=> (RDATA & ~CTRL_USED) == '0)
    else $error("unused control bits read nonzero");

endmodule

// ==== rtl/capture_pkg.sv ====
// Constants, field layout and carrier types of the input capture channel.
// Assumes a single 100 MHz system clock and a plain strobe-based register port.
package capture_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int STAT_W = 2;

  // Register offsets on the plain register port.
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_BUF = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_MASK = 4'hC;

  // Field positions of capture_channel_control.
  localparam int ON_BIT = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int FIRST_EDGE_BIT = 9;
  localparam int WIDE_BIT = 8;
  localparam int TMR_BIT = 7;
  localparam int EVT_LSB = 5;
  localparam int OVF_BIT = 4;
  localparam int BNE_BIT = 3;
  localparam int MODE_LSB = 0;
  localparam logic [DATA_W-1:0] CTRL_USED = 32'h0000_A3FF;

  // Status bit positions, shared by the mask register.
  localparam int ST_CAP = 0;
  localparam int ST_OVF = 1;

  // Capture mode encodings.
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_EVERY = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_FIRST = 3'h6;

  typedef struct packed {
    logic on;
    logic stop_idle;
    logic first_edge;
    logic wide;
    logic tmr_sel;
    logic [1:0] evt_div;
    logic [2:0] mode;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 10'h000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  typedef enum logic [1:0] {
    S_ARM = 2'h1,
    S_RUN = 2'h2
  } edge_state_t;

endpackage

// ==== sim/pin_source.sv ====
// Behavioural source of the captured pin: a level that follows the bench's request.
// Assumes the bench changes want and slow away from the rising edge of CLK_SYS.
`timescale 1ns/1ps

module pin_source (
  input wire logic CLK_SYS,
  input wire logic want,
  input wire logic slow,
  output logic pin
);
  logic [3:0] dly_q = 4'h0;

  // A slow source lags by four cycles, so edges reach the channel late.
  always @(posedge CLK_SYS)
  begin
    dly_q <= {dly_q[2:0], want};
  end

  assign pin = slow ? dly_q[3] : dly_q[0];
endmodule

// ==== sim/input_capture_control_tb.sv ====
// Self-checking bench of the input capture channel over its register port.
// Assumes the package constants and a DEPTH of four captures.
`timescale 1ns/1ps

module input_capture_control_tb;
  import capture_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  bus_req_t req = '0;
  logic [DATA_W-1:0] rdata;
  logic want = 1'b0;
  logic slow = 1'b0;
  logic cap_pin;
  logic [15:0] tmr2 = 16'h1234;
  logic [15:0] tmr3 = 16'hABCD;
  logic idle = 1'b0;
  logic irq;
  logic [DATA_W-1:0] rv;
  int fails = 0;
  int checks = 0;

  always #5 CLK_SYS = ~CLK_SYS;

  pin_source src_u (
    .CLK_SYS(CLK_SYS),
    .want(want),
    .slow(slow),
    .pin(cap_pin)
  );

  input_capture_control #(.DEPTH(4)) dut_u (
    .CLK_SYS(CLK_SYS),
    .RSTN(RSTN),
    .BUS_REQ(req),
    .RDATA(rdata),
    .CAP_PIN(cap_pin),
    .TMR_SECOND(tmr2),
    .TMR_THIRD(tmr3),
    .IDLE_MODE(idle),
    .IRQ(irq)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge CLK_SYS);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe is taken.
  task automatic rd(input logic [3:0] a);
    @(posedge CLK_SYS);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge CLK_SYS);
    req.rd <= 1'b0;
    #1;
    rv = rdata;
  endtask

  // Ten cycles cover the slow source, the synchroniser and the interrupt flop.
  task automatic tog();
    want <= ~want;
    repeat (10) @(posedge CLK_SYS);
  endtask

  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #100us;
    fails++;
    close_out();
  end

  initial
  begin
    repeat (3) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    rd(OFF_CTRL);
    chk(rv, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(OFF_CTRL, 32'hFFFF_FFFF);
    rd(OFF_CTRL);
    chk(rv, 32'h0000_A3E7);
    rd(4'h2);
    chk(rv, 32'h0000_0000);
    @(posedge CLK_SYS);
    #1;
    chk(rdata, 32'h0000_0000);
    // Disable, then leave a quiet cycle before the next access.
    wr(OFF_CTRL, 32'h0000_0000);
    slow <= 1'b1;
    wr(OFF_CTRL, 32'h0000_8001);
    repeat (5) tog();
    rd(OFF_CTRL);
    chk(rv, 32'h0000_8019);
    rd(OFF_STAT);
    chk(rv, 32'h0000_0003);
    rd(OFF_STAT);
    chk(rv, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      rd(OFF_BUF);
      chk(rv, {16'h0, tmr3});
    end
    rd(OFF_CTRL);
    chk(rv, 32'h0000_8011);
    rd(OFF_BUF);
    chk(rv, 32'h0000_0000);
    slow <= 1'b0;
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_8081);
    tog();
    rd(OFF_BUF);
    chk(rv, {16'h0, tmr2});
    wr(OFF_CTRL, 32'h0000_8181);
    tog();
    rd(OFF_BUF);
    chk(rv, {tmr3, tmr2});
    wr(OFF_MASK, 32'h0000_0001);
    for (int n = 0; n < 4; n++)
    begin
      wr(OFF_CTRL, 32'h0000_0000);
      wr(OFF_CTRL, 32'h0000_8001 | (n << EVT_LSB));
      rd(OFF_STAT);
      repeat (n) tog();
      chk({31'h0, irq}, 32'h0000_0000);
      tog();
      chk({31'h0, irq}, 32'h0000_0001);
    end
    wr(OFF_CTRL, 32'h0000_0000);
    // The interrupt flop drops one cycle after the enable bit clears.
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk({31'h0, irq}, 32'h0000_0000);
    rd(OFF_CTRL);
    chk(rv, 32'h0000_0000);
    tog();
    rd(OFF_CTRL);
    chk(rv, 32'h0000_0000);
    idle <= 1'b1;
    wr(OFF_CTRL, 32'h0000_A001);
    tog();
    rd(OFF_CTRL);
    chk(rv, 32'h0000_A001);
    wr(OFF_CTRL, 32'h0000_8001);
    tog();
    rd(OFF_CTRL);
    chk(rv, 32'h0000_8009);
    idle <= 1'b0;
    wr(OFF_CTRL, 32'h0000_0000);
    if (!want)
      tog();
    wr(OFF_CTRL, 32'h0000_8206);
    tog();
    rd(OFF_CTRL);
    chk(rv, 32'h0000_8206);
    tog();
    rd(OFF_CTRL);
    chk(rv, 32'h0000_820E);
    // Falling edge first: the pin now stands high, so the next edge falls.
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_8006);
    tog();
    rd(OFF_CTRL);
    chk(rv, 32'h0000_800E);
    close_out();
  end
endmodule
